// file: design/sfcf_pkg.sv
// Functional notes
// RULE_01: Only serial clock modes 0 and 3; they differ only in idle clock level.
// RULE_02: Inputs sampled on rising serial clock, outputs changed on falling edge.
// RULE_03: Dual output read drives two data lines, two bits per clock.
// RULE_04: Quad output read drives all four data lines, four bits per clock.
// RULE_05: Master asserts chip select before any clocked information.
// RULE_06: Master shifts an 8-bit opcode first, then address and data bytes.
// RULE_07: Opcode, address and data bytes travel most significant bit first.
// RULE_08: Chip select deassertion ends the current operation.
// RULE_09: Unsupported opcode starts nothing; input ignored until chip select toggles.
// RULE_10: Frame cut before opcode and address complete performs nothing.
// RULE_11: Addressed instructions carry three address bytes, bits 23 down to 0.
// RULE_12: Top four address bits ignored; only low 20 bits select a location.
// RULE_13: Erase in 4KB, 32KB, 64KB blocks and whole chip.
// RULE_14: Program writes 1 to 256 bytes inside one aligned 256-byte page.
// RULE_15: Erase blocks are naturally aligned within sectors and halves.
// RULE_16: Serial output floats whenever chip select is deasserted.
// RULE_17: Pause starts only when selected with clock low; floats output meanwhile.
// RULE_18: Master releases every line the device drives during multi-line reads.
package sfcf_pkg;
  localparam int MCLK_PERIOD_NS = 25;
  localparam int OPC_BITS       = 8;
  localparam int ADR_BITS       = 24;
  localparam int ARR_BITS       = 20;
  localparam int DMY_BITS       = 8;
  localparam int PAGE_BITS      = 8;
  localparam logic [4:0] OPC_LAST = 5'h07;
  localparam logic [4:0] ADR_LAST = 5'h17;
  localparam logic [4:0] DMY_LAST = 5'h07;
  localparam logic [19:0] MASK_4K  = 20'hff000;
  localparam logic [19:0] MASK_32K = 20'hf8000;
  localparam logic [19:0] MASK_64K = 20'hf0000;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_FAST  = 8'h0b;
  localparam logic [7:0] OP_DUAL  = 8'h3b;
  localparam logic [7:0] OP_QUAD  = 8'h6b;
  localparam logic [7:0] OP_ER4   = 8'h20;
  localparam logic [7:0] OP_ER32  = 8'h52;
  localparam logic [7:0] OP_ER64  = 8'hd8;
  localparam logic [7:0] OP_CHIP1 = 8'h60;
  localparam logic [7:0] OP_CHIP2 = 8'hc7;
  localparam logic [7:0] OP_PROG  = 8'h02;

  typedef enum logic [3:0] {
    KIND_NONE = 4'h0,
    KIND_READ = 4'h1,
    KIND_FAST = 4'h2,
    KIND_DUAL = 4'h3,
    KIND_QUAD = 4'h4,
    KIND_ER4  = 4'h5,
    KIND_ER32 = 4'h6,
    KIND_ER64 = 4'h7,
    KIND_CHIP = 4'h8,
    KIND_PROG = 4'h9
  } sfcf_kind_e;

  typedef enum logic [6:0] {
    ST_OPC = 7'b0000001,
    ST_ADR = 7'b0000010,
    ST_DMY = 7'b0000100,
    ST_PRG = 7'b0001000,
    ST_RDO = 7'b0010000,
    ST_IGN = 7'b0100000,
    ST_END = 7'b1000000
  } sfcf_state_e;
endpackage : sfcf_pkg

// file: design/sfcf_front_end.sv
`timescale 1ns/1ps
module sfcf_front_end (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // Serial pins
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic [3:0]        io_in,
  output logic      [3:0]        io_out,
  output logic      [3:0]        io_oe,
  // Command side
  output logic                   cmd_valid,
  output sfcf_pkg::sfcf_kind_e   cmd_kind,
  output logic      [19:0]       cmd_addr,
  // Program data side
  output logic                   prog_valid,
  output logic      [7:0]        prog_data,
  output logic      [19:0]       prog_addr,
  // Array read side
  output logic                   rd_req,
  output logic      [19:0]       rd_addr,
  input  wire logic [7:0]        rd_data
);
  logic [1:0]            cs_s;
  logic [1:0]            sck_s;
  logic [3:0]            io_s1;
  logic [3:0]            io_s2;
  logic                  sck_d;
  logic                  cs_d;
  logic                  paused;
  sfcf_pkg::sfcf_state_e state;
  sfcf_pkg::sfcf_kind_e  kind;
  logic [4:0]            cnt;
  logic [7:0]            sh_in;
  logic [23:0]           addr;
  logic                  armed;
  logic [7:0]            out_sh;
  logic [7:0]            nxt;
  logic                  rd_pend;
  logic                  live;
  logic [3:0]            next_oe;

  // Two flops on every pin before use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cs_s  <= 2'h3;
      sck_s <= 2'h0;
      io_s1 <= 4'hf;
      io_s2 <= 4'hf;
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      cs_s  <= {cs_s[0], cs_n};
      sck_s <= {sck_s[0], sck};
      io_s1 <= io_in;
      io_s2 <= io_s1;
      sck_d <= sck_s[1];
      cs_d  <= cs_s[1];
    end
  end

  // Idle level of the clock never matters, so modes 0 and 3 both work
  wire sel      = ~cs_s[1];
  wire rise     = sck_s[1] & ~sck_d; // RULE_01
  wire fall     = ~sck_s[1] & sck_d; // RULE_01
  wire cs_rise  = cs_s[1] & ~cs_d;
  wire act_rise = rise & sel & ~paused; // RULE_02
  wire act_fall = fall & sel & ~paused; // RULE_02
  wire bit_in   = io_s2[0];
  wire [7:0] byte_in = {sh_in[6:0], bit_in}; // RULE_07
  wire [23:0] addr_in = {addr[22:0], bit_in}; // RULE_07 RULE_11
  wire [2:0] width = (kind == sfcf_pkg::KIND_QUAD) ? 3'h4 :
                     (kind == sfcf_pkg::KIND_DUAL) ? 3'h2 : 3'h1;
  wire quad_drive = (state == sfcf_pkg::ST_RDO) && (width == 3'h4);

  // Opcode decode; anything absent from the list is unsupported
  wire sfcf_pkg::sfcf_kind_e op_kind =
    (byte_in == sfcf_pkg::OP_READ)  ? sfcf_pkg::KIND_READ :
    (byte_in == sfcf_pkg::OP_FAST)  ? sfcf_pkg::KIND_FAST :
    (byte_in == sfcf_pkg::OP_DUAL)  ? sfcf_pkg::KIND_DUAL :
    (byte_in == sfcf_pkg::OP_QUAD)  ? sfcf_pkg::KIND_QUAD :
    (byte_in == sfcf_pkg::OP_ER4)   ? sfcf_pkg::KIND_ER4  :
    (byte_in == sfcf_pkg::OP_ER32)  ? sfcf_pkg::KIND_ER32 :
    (byte_in == sfcf_pkg::OP_ER64)  ? sfcf_pkg::KIND_ER64 :
    (byte_in == sfcf_pkg::OP_CHIP1) ? sfcf_pkg::KIND_CHIP :
    (byte_in == sfcf_pkg::OP_CHIP2) ? sfcf_pkg::KIND_CHIP :
    (byte_in == sfcf_pkg::OP_PROG)  ? sfcf_pkg::KIND_PROG : sfcf_pkg::KIND_NONE;
  wire is_read  = (kind == sfcf_pkg::KIND_READ) || (kind == sfcf_pkg::KIND_FAST) ||
                  (kind == sfcf_pkg::KIND_DUAL) || (kind == sfcf_pkg::KIND_QUAD);
  wire is_erase = (kind == sfcf_pkg::KIND_ER4) || (kind == sfcf_pkg::KIND_ER32) ||
                  (kind == sfcf_pkg::KIND_ER64);
  wire [19:0] erase_mask = (kind == sfcf_pkg::KIND_ER4)  ? sfcf_pkg::MASK_4K  :
                           (kind == sfcf_pkg::KIND_ER32) ? sfcf_pkg::MASK_32K :
                           (kind == sfcf_pkg::KIND_ER64) ? sfcf_pkg::MASK_64K : 20'h00000;
  wire load_word = act_fall && (state == sfcf_pkg::ST_RDO) && (cnt == 5'h00);
  wire [7:0] word = load_word ? nxt : out_sh;
  wire [3:0] out_bits = (width == 3'h4) ? word[7:4] :
                        (width == 3'h2) ? {2'h0, word[7:6]} : {2'h0, word[7], 1'b0};
  wire [3:0] run_oe = (width == 3'h4) ? 4'hf : (width == 3'h2) ? 4'h3 : 4'h2;

  // Pause may only begin, or end by the pin, while the clock is low; deselect ends it at any time; not in quad, where the pin drives
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      paused <= 1'b0;
    end else if (!sel || quad_drive) begin
      paused <= 1'b0;
    end else if (!sck_s[1]) begin
      paused <= ~io_s2[3]; // RULE_17
    end
  end

  // Frame sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= sfcf_pkg::ST_OPC;
      kind       <= sfcf_pkg::KIND_NONE;
      cnt        <= 5'h00;
      sh_in      <= 8'h00;
      addr       <= 24'h000000;
      armed      <= 1'b0;
      cmd_valid  <= 1'b0;
      cmd_kind   <= sfcf_pkg::KIND_NONE;
      cmd_addr   <= 20'h00000;
      prog_valid <= 1'b0;
      prog_data  <= 8'h00;
      prog_addr  <= 20'h00000;
      rd_req     <= 1'b0;
      rd_addr    <= 20'h00000;
    end else begin
      cmd_valid  <= 1'b0;
      prog_valid <= 1'b0;
      rd_req     <= 1'b0;
      if (!sel) begin
        // Deselect ends the frame; only a complete frame leaves a command behind
        if (cs_rise && armed) begin // RULE_08 RULE_10
          cmd_valid <= 1'b1;
          cmd_kind  <= kind;
          cmd_addr  <= addr[19:0] & erase_mask; // RULE_13 RULE_15
        end
        state <= sfcf_pkg::ST_OPC;
        kind  <= sfcf_pkg::KIND_NONE;
        cnt   <= 5'h00;
        armed <= 1'b0;
      end else if (act_rise) begin
        sh_in <= byte_in;
        cnt   <= cnt + 5'h01;
        case (state)
          sfcf_pkg::ST_OPC: begin
            if (cnt == sfcf_pkg::OPC_LAST) begin // RULE_06
              kind <= op_kind;
              cnt  <= 5'h00;
              if (op_kind == sfcf_pkg::KIND_NONE) begin
                state <= sfcf_pkg::ST_IGN; // RULE_09
              end else if (op_kind == sfcf_pkg::KIND_CHIP) begin
                state <= sfcf_pkg::ST_END;
                armed <= 1'b1; // RULE_13
              end else begin
                state <= sfcf_pkg::ST_ADR;
              end
            end
          end
          sfcf_pkg::ST_ADR: begin
            addr <= addr_in;
            if (cnt == sfcf_pkg::ADR_LAST) begin // RULE_11
              cnt <= 5'h00;
              if (is_erase) begin
                state <= sfcf_pkg::ST_END;
                armed <= 1'b1;
              end else if (kind == sfcf_pkg::KIND_PROG) begin
                state     <= sfcf_pkg::ST_PRG;
                prog_addr <= addr_in[19:0]; // RULE_12
              end else if (kind == sfcf_pkg::KIND_READ) begin
                state   <= sfcf_pkg::ST_RDO;
                rd_req  <= 1'b1;
                rd_addr <= addr_in[19:0]; // RULE_12
              end else begin
                state   <= sfcf_pkg::ST_DMY;
                rd_addr <= addr_in[19:0]; // RULE_12
              end
            end
          end
          sfcf_pkg::ST_DMY: begin
            if (cnt == sfcf_pkg::DMY_LAST) begin
              state  <= sfcf_pkg::ST_RDO;
              cnt    <= 5'h00;
              rd_req <= 1'b1;
            end
          end
          sfcf_pkg::ST_PRG: begin
            if (cnt == 5'h07) begin
              cnt        <= 5'h00;
              armed      <= 1'b1;
              prog_valid <= 1'b1;
              prog_data  <= byte_in;
              prog_addr  <= prog_addr;
            end
          end
          default: begin
            cnt <= cnt;
          end
        endcase
      end else if (act_fall && state == sfcf_pkg::ST_RDO) begin
        // Refill: one byte already waits in nxt, ask for the one after it
        if (cnt == 5'h00) begin
          cnt     <= (width == 3'h4) ? 5'h01 : (width == 3'h2) ? 5'h03 : 5'h07;
          rd_req  <= 1'b1;
          rd_addr <= rd_addr + 20'h00001;
        end else begin
          cnt <= cnt - 5'h01;
        end
      end
      // Page wrap keeps the stream inside one 256-byte page
      if (prog_valid) begin
        prog_addr <= {prog_addr[19:8], prog_addr[7:0] + 8'h01}; // RULE_14
      end
    end
  end

  // Read path: array answers one cycle after the request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend <= 1'b0;
      live    <= 1'b0;
      nxt     <= 8'h00;
      out_sh  <= 8'h00;
      io_out  <= 4'h0;
      io_oe   <= 4'h0;
    end else begin
      rd_pend <= rd_req;
      // Remembers that the data phase has begun, so a pause can hand the lines back
      if (!sel || state != sfcf_pkg::ST_RDO) begin
        live <= 1'b0;
      end else if (act_fall) begin
        live <= 1'b1; // RULE_17
      end
      if (rd_pend) begin
        nxt <= rd_data;
      end
      if (act_fall && state == sfcf_pkg::ST_RDO) begin
        io_out <= out_bits; // RULE_02 RULE_07
        out_sh <= word << width;
      end
      io_oe <= next_oe;
    end
  end

  // Drivers float when deselected or paused
  always_comb begin
    next_oe = io_oe;
    if (!sel || paused || state != sfcf_pkg::ST_RDO) begin
      next_oe = 4'h0; // RULE_16 RULE_17
    end else if (act_fall || live) begin
      // Drive resumes after a pause without waiting for the next falling clock
      next_oe = run_oe; // RULE_03 RULE_04 RULE_18
    end
  end

  oe_off_desel_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_16
    !sel |=> io_oe == 4'h0) else $error("Output driven while deselected");
  pause_float_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_17
    paused |=> io_oe == 4'h0) else $error("Output driven during pause");
  out_on_fall_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_02
    $changed(io_out) |-> $past(act_fall)) else $error("Output moved off a falling edge");
  dual_lines_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_03
    io_oe == 4'h3 |-> kind == sfcf_pkg::KIND_DUAL) else $error("Two lines outside dual read");
  quad_lines_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_04
    io_oe == 4'hf |-> kind == sfcf_pkg::KIND_QUAD) else $error("Four lines outside quad read");
  ignore_quiet_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_09
    state == sfcf_pkg::ST_IGN |=> !rd_req && !prog_valid && io_oe == 4'h0)
    else $error("Activity after unsupported opcode");
  trunc_none_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_10
    cs_rise && !armed |=> !cmd_valid) else $error("Command from cut frame");
  erase_align_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_15
    cmd_valid && cmd_kind == sfcf_pkg::KIND_ER32 |-> cmd_addr[14:0] == 15'h0000)
    else $error("Erase block misaligned");
  page_stay_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_14
    state == sfcf_pkg::ST_PRG && $past(state) == sfcf_pkg::ST_PRG
      |-> prog_addr[19:8] == $past(prog_addr[19:8])) else $error("Program left its page");
  opc_length_a: assert property (@(posedge mclk) disable iff (!arst_n) // RULE_06
    state == sfcf_pkg::ST_ADR && $past(state) == sfcf_pkg::ST_OPC |-> $past(cnt) == 5'h07)
    else $error("Opcode not eight bits");
endmodule : sfcf_front_end

// file: verif/sfcf_host_model.sv
`timescale 1ns/1ps
module sfcf_host_model (
  // Clock
  input  wire logic       mclk,
  // Device pins
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  output logic            cs_n,
  output logic            sck,
  output logic      [3:0] io_in
);
  logic [3:0] drv;
  logic [3:0] rel;
  logic       flip;
  bit         m3;

  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    drv  = 4'hc;
    rel  = 4'h2;
    flip = 1'b0;
    m3   = 1'b0;
  end

  // Undriven lines 0 and 1 must not look stable: pull-ups on 2 and 3, a toggling pattern on 0 and 1
  always @(posedge mclk) flip <= ~flip;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_in[i] = io_oe[i] ? io_out[i] : !rel[i] ? drv[i] : (i > 1) ? 1'b1 : flip ^ i[0];
    end
  end

  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask : w

  // One serial period: data set after the fall, sampled at the end of the high phase
  task automatic cyc(input logic si, output logic [3:0] q);
    sck <= 1'b0;
    drv[0] <= si;
    // Write protect wiggles as well; this block must not react to it
    drv[2] <= ~si;
    w(4);
    sck <= 1'b1;
    w(4);
    q = io_in;
  endtask : cyc

  task automatic open_f(input bit mode3);
    m3 = mode3;
    sck <= mode3;
    rel <= 4'h2;
    w(4);
    cs_n <= 1'b0;
    w(4);
  endtask : open_f

  task automatic send(input logic [31:0] v, input int n);
    logic [3:0] q;
    for (int i = n - 1; i >= 0; i--) cyc(v[i], q);
  endtask : send

  task automatic release_lines;
    rel <= 4'hf;
  endtask : release_lines

  task automatic close_f;
    sck <= m3;
    w(4);
    cs_n <= 1'b1;
    w(8);
  endtask : close_f

  // Pause only with the clock low; garbage clocks inside must be ignored
  task automatic pause_gap;
    logic [3:0] q;
    sck <= 1'b0;
    w(4);
    drv[3] <= 1'b0;
    w(4);
    repeat (3) cyc(1'b1, q);
    sck <= 1'b0;
    w(4);
    drv[3] <= 1'b1;
    w(4);
  endtask : pause_gap
endmodule : sfcf_host_model

// file: verif/sfcf_front_end_tb_top.sv
`timescale 1ns/1ps
module sfcf_front_end_tb_top;
  logic                 mclk;
  logic                 arst_n;
  logic                 cs_n;
  logic                 sck;
  logic [3:0]           io_in;
  logic [3:0]           io_out;
  logic [3:0]           io_oe;
  logic                 cmd_valid;
  sfcf_pkg::sfcf_kind_e cmd_kind;
  logic [19:0]          cmd_addr;
  logic                 prog_valid;
  logic [7:0]           prog_data;
  logic [19:0]          prog_addr;
  logic                 rd_req;
  logic [19:0]          rd_addr;
  logic [7:0]           rd_data;
  int                   mismatches;
  int                   num_checks;
  int                   cmd_n;
  int                   cycles;
  logic [27:0]          progq[$];
  sfcf_pkg::sfcf_kind_e last_kind;
  logic [19:0]          last_addr;

  sfcf_front_end uut (.mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .prog_valid(prog_valid), .prog_data(prog_data),
    .prog_addr(prog_addr), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data));
  sfcf_host_model host (.mclk(mclk), .io_out(io_out), .io_oe(io_oe), .cs_n(cs_n),
    .sck(sck), .io_in(io_in));

  // Array content mixes high and low address bits so a wrong address shows
  function automatic logic [7:0] arr(input logic [19:0] a);
    return a[7:0] ^ {a[19:16], a[11:8]};
  endfunction : arr

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (rd_req === 1'b1) rd_data <= arr(rd_addr);
    if (cmd_valid === 1'b1) begin
      cmd_n++;
      last_kind = cmd_kind;
      last_addr = cmd_addr;
    end
    if (prog_valid === 1'b1) progq.push_back({prog_addr, prog_data});
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic t_erase;
    logic [7:0]           op [5];
    sfcf_pkg::sfcf_kind_e k [5];
    logic [19:0]          m [5];
    int                   n0;
    op = '{sfcf_pkg::OP_ER4, sfcf_pkg::OP_ER32, sfcf_pkg::OP_ER64, sfcf_pkg::OP_CHIP1,
           sfcf_pkg::OP_CHIP2};
    k = '{sfcf_pkg::KIND_ER4, sfcf_pkg::KIND_ER32, sfcf_pkg::KIND_ER64, sfcf_pkg::KIND_CHIP,
          sfcf_pkg::KIND_CHIP};
    m = '{sfcf_pkg::MASK_4K, sfcf_pkg::MASK_32K, sfcf_pkg::MASK_64K, 20'h0, 20'h0};
    for (int i = 0; i < 5; i++) begin
      n0 = cmd_n;
      host.open_f(i[0]);
      host.send(op[i], 8);
      if (i < 3) host.send(32'h00fabcde, 24);
      host.close_f();
      chk(cmd_n - n0, 1);
      chk(last_kind, k[i]);
      chk(last_addr, 20'habcde & m[i]);
    end
    $display("test erase done");
  endtask : t_erase

  task automatic t_abort;
    int n0;
    n0 = cmd_n;
    host.open_f(1'b0);
    host.send(sfcf_pkg::OP_ER4, 8);
    host.send(32'h1234, 16);
    host.close_f();
    host.open_f(1'b1);
    host.send(8'h06, 8);
    host.send({sfcf_pkg::OP_ER4, 24'h012345}, 32);
    host.close_f();
    host.open_f(1'b0);
    host.send(32'ha, 4);
    host.close_f();
    chk(cmd_n - n0, 0);
    host.open_f(1'b1);
    host.send(sfcf_pkg::OP_ER4, 8);
    host.send(32'h0f, 8);
    host.pause_gap();
    host.send(32'h9abc, 16);
    host.close_f();
    chk(cmd_n - n0, 1);
    chk(last_addr, 20'hf9000);
    $display("test abort and pause done");
  endtask : t_abort

  task automatic t_prog;
    int n0;
    n0 = cmd_n;
    progq.delete();
    host.open_f(1'b0);
    host.send(sfcf_pkg::OP_PROG, 8);
    host.send(32'h5123fe, 24);
    host.send(32'ha1b2c3, 24);
    host.send(32'h5, 4);
    host.close_f();
    chk(progq.size(), 3);
    for (int i = 0; i < 3; i++) begin
      chk(progq[i], {12'h123, 8'(8'hfe + i), 8'(8'ha1 + 8'h11 * i)});
    end
    chk(cmd_n - n0, 1);
    chk(last_kind, sfcf_pkg::KIND_PROG);
    $display("test program done");
  endtask : t_prog

  task automatic t_read;
    logic [7:0] op [4];
    int         wd [4];
    logic [3:0] oe [4];
    logic [3:0] q;
    logic [7:0] b;
    op = '{sfcf_pkg::OP_READ, sfcf_pkg::OP_FAST, sfcf_pkg::OP_DUAL, sfcf_pkg::OP_QUAD};
    wd = '{1, 1, 2, 4};
    oe = '{4'h2, 4'h2, 4'h3, 4'hf};
    for (int i = 0; i < 4; i++) begin
      host.open_f(i[1]);
      host.send(op[i], 8);
      host.send(32'ha5ffff, 24);
      if (i > 0) host.send(32'h0, 8);
      if (i > 1) host.release_lines();
      for (int j = 0; j < 2; j++) begin
        b = 8'h00;
        for (int c = 0; c < 8 / wd[i]; c++) begin
          host.cyc(1'b0, q);
          b = (wd[i] == 1) ? {b[6:0], q[1]} : (wd[i] == 2) ? {b[5:0], q[1:0]} : {b[3:0], q};
        end
        chk(b, arr(20'(20'h5ffff + j)));
        chk(io_oe, oe[i]);
        if (i == 0 && j == 0) host.pause_gap();
      end
      host.close_f();
      chk(io_oe, 4'h0);
    end
    $display("test read done");
  endtask : t_read

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    arst_n = 1'b0;
    rd_data = 8'h00;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    host.w(4);
    t_erase();
    t_abort();
    t_prog();
    t_read();
    stop_test();
  end
endmodule : sfcf_front_end_tb_top
